// ==== logic/tcc_consts.svh ====
/*
 * Register indices, field positions, reset values and divider counts for the
 * timer capture/compare unit. Assumes a 32-bit bus where index N sits at byte 4*N.
 */
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH

// ==========================================================================
// Register indices
`define TCC_IDX_AUX      8'h91
`define TCC_IDX_CHANNEL_MODE_SELECT     8'hC1
`define TCC_IDX_CH1_LO   8'hC2
`define TCC_IDX_CH1_HI   8'hC3
`define TCC_IDX_CH2_LO   8'hC4
`define TCC_IDX_CH2_HI   8'hC5
`define TCC_IDX_CH3_LO   8'hC6
`define TCC_IDX_CH3_HI   8'hC7
`define TCC_IDX_TCON     8'hC8
`define TCC_IDX_CHANNEL_IRQ_CONTROL    8'hC9
`define TCC_IDX_CH0_LO   8'hCA
`define TCC_IDX_CH0_HI   8'hCB
`define TCC_IDX_CNT_LO   8'hCC
`define TCC_IDX_CNT_HI   8'hCD
`define TCC_IDX_LATCH    8'hCE

// ==========================================================================
// Field positions
`define TCC_AUX_ROUTE    6
`define TCC_TCON_PS      7
`define TCC_TCON_EDGE    6
`define TCC_TCON_RM_HI   4
`define TCC_TCON_RM_LO   3
`define TCC_TCON_CM      2
`define TCC_TCON_IS_HI   1
`define TCC_TCON_IS_LO   0

// ==========================================================================
// Reset values and counts
`define TCC_RST_BYTE     8'h00
`define TCC_RST_WORD     16'h0000
`define TCC_CNT_MAX      16'hFFFF
`define TCC_DIV_FAST     5'h0C
`define TCC_DIV_SLOW     5'h18

`endif

// ==== logic/tcc_pkg.sv ====
/*
 * Types of the timer capture/compare unit: mode encodings and the packed
 * state record. Assumes the constants header is included by the user.
 */
package tcc_pkg;

  // ========================================================================
  // Mode encodings
  typedef enum logic [1:0] {
    TCC_IN_STOP  = 2'h0,
    TCC_IN_CLOCK = 2'h1,
    TCC_IN_EVENT = 2'h2,
    TCC_IN_GATED = 2'h3
  } tcc_input_t;

  typedef enum logic [1:0] {
    TCC_CH_OFF     = 2'h0,
    TCC_CH_CAP_PIN = 2'h1,
    TCC_CH_COMPARE = 2'h2,
    TCC_CH_CAP_SW  = 2'h3
  } tcc_chmode_t;

  // ========================================================================
  // Whole state of the unit
  typedef struct packed {
    logic [7:0]       aux;
    logic [7:0]       channel_mode_select;
    logic [7:0]       tcon;
    logic [3:0]       ien;
    logic [3:0]       flag;
    logic [3:0][15:0] val;
    logic [15:0]      count;
    logic [4:0]       presc;
    logic             evt_prev;
    logic             evt_hit;
    logic             trig_prev;
    logic [3:0]       pin_prev;
    logic [3:0]       pin_out;
    logic [3:0]       shadow;
    logic             ack;
    logic [7:0]       dat;
  } tcc_state_t;

endpackage

// ==== logic/tcc_top.sv ====
/*
 * Timer 2 with a reload/capture/compare channel 0 and three further
 * capture/compare channels, reached as a classic Wishbone slave.
 * Assumes all pin inputs are synchronous to clk_i, and that clk_i is the
 * oscillator from which the count rates are divided.
 */
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ns
`include "tcc_consts.svh"

module tcc_top (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [9:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output wire logic [31:0] dat_o,
  output wire logic        ack_o,
  // Timer pins
  input  wire logic        event_gate_pin_i,
  input  wire logic        reload_trigger_pin_i,
  // Channel pins on port 1
  input  wire logic [3:0]  p1_cc_i,
  output wire logic [3:0]  p1_cc_o,
  output wire logic [3:0]  p1_cc_oe_o,
  // Channel pins on port 4
  input  wire logic [3:0]  p4_cc_i,
  output wire logic [3:0]  p4_cc_o,
  output wire logic [3:0]  p4_cc_oe_o,
  // Interrupt request
  output wire logic        irq_o
);

  // ========================================================================
  // State and decoding
  tcc_pkg::tcc_state_t r;
  tcc_pkg::tcc_state_t next_r;

  logic [7:0]  idx;
  logic        req;
  logic        wr;
  logic [7:0]  wdat;
  logic        route;
  logic [3:0]  pin_in;
  logic [3:0]  cmp_en;
  logic [3:0]  cap_pin;
  logic [3:0]  lo_wr;
  logic [3:0]  hi_wr;
  logic [3:0]  cap_sw;
  tcc_pkg::tcc_input_t isel;

  assign idx  = adr_i[9:2];
  assign req  = cyc_i & stb_i;
  // A write takes effect at the edge where the master sees ack.
  assign wr   = req & we_i & r.ack & sel_i[0];
  assign wdat = dat_i[7:0];
  assign isel = tcc_pkg::tcc_input_t'(r.tcon[`TCC_TCON_IS_HI:`TCC_TCON_IS_LO]);

  assign route  = r.aux[`TCC_AUX_ROUTE];
  assign pin_in = route ? p4_cc_i : p1_cc_i;

  // Channel 0 keeps its value in the reload pair, so its low byte does not
  // follow the other channels' run of indices.
  function automatic logic [7:0] lo_index(input int ch);
    logic [7:0] res;
    res = `TCC_IDX_CH0_LO;
    if (ch == 1)
    begin
      res = `TCC_IDX_CH1_LO;
    end
    else if (ch == 2)
    begin
      res = `TCC_IDX_CH2_LO;
    end
    else if (ch == 3)
    begin
      res = `TCC_IDX_CH3_LO;
    end
    return res;
  endfunction

  // ========================================================================
  // Per-channel decoding
  // Edges are taken against the previous sample of the routed port, so a
  // change of routing can itself look like an edge for one cycle.
  for (genvar i = 0; i < 4; i++)
  begin : g_ch
    tcc_pkg::tcc_chmode_t mode;
    logic                 rise;
    logic                 fall;
    logic                 hit;

    assign mode = tcc_pkg::tcc_chmode_t'(r.channel_mode_select[2*i+1 -: 2]);
    assign rise = pin_in[i] & ~r.pin_prev[i];
    assign fall = ~pin_in[i] & r.pin_prev[i];
    if (i == 0)
    begin : g_ch0
      assign hit = r.tcon[`TCC_TCON_EDGE] ? rise : fall;
    end
    else
    begin : g_chn
      assign hit = rise;
    end
    assign lo_wr[i]   = wr & (idx == lo_index(i));
    assign hi_wr[i]   = wr & (idx == lo_index(i) + 8'h01);
    assign cmp_en[i]  = (mode == tcc_pkg::TCC_CH_COMPARE);
    assign cap_pin[i] = (mode == tcc_pkg::TCC_CH_CAP_PIN) & hit;
    assign cap_sw[i]  = (mode == tcc_pkg::TCC_CH_CAP_SW) & lo_wr[i];
  end

  // ========================================================================
  // Next state
  logic        tick;
  logic        inc;
  logic        ovf;
  logic        reload_edge;
  logic [4:0]  div;
  logic [3:0]  match;
  logic [3:0]  event_set;
  logic [1:0]  rmode;

  always_comb
  begin
    next_r = r;
    rmode  = r.tcon[`TCC_TCON_RM_HI:`TCC_TCON_RM_LO];
    match  = 4'h0;

    // prescaler
    // The guard against a count past the divider keeps a switch from the slow to
    // the fast rate from stalling the timer for a whole wrap of the prescaler.
    div  = r.tcon[`TCC_TCON_PS] ? `TCC_DIV_SLOW : `TCC_DIV_FAST;
    tick = (r.presc == div - 5'h01);
    next_r.presc = (tick || r.presc >= div) ? 5'h00 : r.presc + 5'h01;

    // event detect, increment a cycle later
    next_r.evt_prev = event_gate_pin_i;
    next_r.evt_hit  = r.evt_prev & ~event_gate_pin_i;
    next_r.trig_prev = reload_trigger_pin_i;
    next_r.pin_prev  = pin_in;

    // count source
    // Only one of the four sources may advance the timer in a cycle.
    unique case (isel)
      tcc_pkg::TCC_IN_STOP:
      begin
        inc = 1'b0;
      end
      tcc_pkg::TCC_IN_CLOCK:
      begin
        inc = tick;
      end
      tcc_pkg::TCC_IN_EVENT:
      begin
        // The edge was registered a cycle ago, so counting lags it by one.
        inc = r.evt_hit;
      end
      tcc_pkg::TCC_IN_GATED:
      begin
        // A low gate swallows the tick; the prescaler keeps its own phase.
        inc = tick & event_gate_pin_i;
      end
    endcase

    ovf = inc & (r.count == `TCC_CNT_MAX);
    reload_edge = (rmode == 2'h3) & r.trig_prev & ~reload_trigger_pin_i;

    if (ovf)
    begin
      // reload on overflow only in mode 10
      next_r.count = (rmode == 2'h2) ? r.val[0] : `TCC_RST_WORD;
    end
    else if (inc)
    begin
      next_r.count = r.count + 16'h0001;
    end
    if (reload_edge)
    begin
      next_r.count = r.val[0];
    end

    // Software register writes; counter writes win over counting.
    if (wr)
    begin
      // The counter bytes are written one at a time; software that needs a
      // consistent 16-bit value must stop the timer first.
      unique case (idx)
        `TCC_IDX_AUX:
        begin
          next_r.aux = wdat;
        end
        `TCC_IDX_CHANNEL_MODE_SELECT:
        begin
          next_r.channel_mode_select = wdat;
        end
        `TCC_IDX_TCON:
        begin
          next_r.tcon = wdat;
        end
        `TCC_IDX_CNT_LO:
        begin
          next_r.count[7:0] = wdat;
        end
        `TCC_IDX_CNT_HI:
        begin
          next_r.count[15:8] = wdat;
        end
        `TCC_IDX_CHANNEL_IRQ_CONTROL:
        begin
          next_r.ien = wdat[7:4];
        end
        default:
        begin
          next_r.ien = r.ien;
        end
      endcase
    end

    for (int i = 0; i < 4; i++)
    begin
      if (hi_wr[i])
      begin
        next_r.val[i][15:8] = wdat;
      end
      if (lo_wr[i] && !cap_sw[i])
      begin
        next_r.val[i][7:0] = wdat;
      end
      // write capture, written byte dropped
      // Capture stores the count before this cycle's increment, so an edge and
      // a tick in one cycle see the older value.
      if (cap_pin[i] || cap_sw[i])
      begin
        next_r.val[i] = r.count;
      end

      // match taken on the new count, so the pin moves with it
      // Requiring a change of count keeps a standing equality from firing
      // every cycle while the timer is stopped.
      match[i] = cmp_en[i] & (next_r.count == r.val[i])
                 & (next_r.count != r.count);
      if (cmp_en[i])
      begin
        // one mode bit for all channels
        if (!r.tcon[`TCC_TCON_CM])
        begin
          // set on match, clear on overflow
          if (match[i])
          begin
            next_r.pin_out[i] = 1'b1;
          end
          else if (ovf)
          begin
            next_r.pin_out[i] = 1'b0;
          end
        end
        else if (match[i])
        begin
          // shadow goes out on match only
          next_r.pin_out[i] = r.shadow[i];
        end
      end
    end

    // latch writes only reach the shadow in compare mode 1
    if (wr && idx == `TCC_IDX_LATCH && r.tcon[`TCC_TCON_CM])
    begin
      next_r.shadow = wdat[3:0];
    end

    // sticky flags, a hardware set beats a software clear
    event_set = match | cap_pin | cap_sw;
    next_r.flag = r.flag | event_set;
    if (wr && idx == `TCC_IDX_CHANNEL_IRQ_CONTROL)
    begin
      next_r.flag = (r.flag & wdat[3:0]) | event_set;
    end

    // Bus answer: one cycle after the request, dropped the cycle after.
    next_r.ack = req & ~r.ack;
    unique case (idx)
      `TCC_IDX_AUX:    next_r.dat = r.aux;
      `TCC_IDX_CHANNEL_MODE_SELECT:   next_r.dat = r.channel_mode_select;
      `TCC_IDX_CH1_LO: next_r.dat = r.val[1][7:0];
      `TCC_IDX_CH1_HI: next_r.dat = r.val[1][15:8];
      `TCC_IDX_CH2_LO: next_r.dat = r.val[2][7:0];
      `TCC_IDX_CH2_HI: next_r.dat = r.val[2][15:8];
      `TCC_IDX_CH3_LO: next_r.dat = r.val[3][7:0];
      `TCC_IDX_CH3_HI: next_r.dat = r.val[3][15:8];
      `TCC_IDX_TCON:   next_r.dat = r.tcon;
      `TCC_IDX_CHANNEL_IRQ_CONTROL:  next_r.dat = {r.ien, r.flag};
      `TCC_IDX_CH0_LO: next_r.dat = r.val[0][7:0];
      `TCC_IDX_CH0_HI: next_r.dat = r.val[0][15:8];
      `TCC_IDX_CNT_LO: next_r.dat = r.count[7:0];
      `TCC_IDX_CNT_HI: next_r.dat = r.count[15:8];
      `TCC_IDX_LATCH:  next_r.dat = {r.shadow, r.pin_out};
      default:         next_r.dat = `TCC_RST_BYTE;
    endcase
  end

  // ========================================================================
  // State register
  // Reset clears every field at once; a channel pin high at release reads
  // as a rising edge in the first cycle after it.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  // ========================================================================
  // Outputs
  assign ack_o = r.ack;
  assign dat_o = {24'h000000, r.dat};

  // only the selected port drives
  // The other port is held low so its pins stay free for their other uses.
  assign p1_cc_o    = route ? 4'h0 : r.pin_out;
  assign p1_cc_oe_o = route ? 4'h0 : cmp_en;
  assign p4_cc_o    = route ? r.pin_out : 4'h0;
  assign p4_cc_oe_o = route ? cmp_en : 4'h0;

  assign irq_o = |(r.flag & r.ien);

endmodule

// ==== tb/tcc_monitor.sv ====
/* Checker of tcc_top port relations.
   Assumes a bind to tcc_top; sees its ports only. */
`timescale 1ns/1ns
module tcc_monitor (
  // Clock, reset and bus
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // Pins
  input wire logic [3:0]  p1_cc_o,
  input wire logic [3:0]  p1_cc_oe_o,
  input wire logic [3:0]  p4_cc_oe_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ==========
  // Properties
  property p_ack_next; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  property p_ack_pulse; ack_o |=> !ack_o; endproperty
  property p_rd_zero; ack_o && !we_i |-> dat_o[31:8] == 24'h000000; endproperty
  property p_quiet;
    $fell(rst_i) |-> !ack_o && !irq_o && p1_cc_oe_o == 4'h0 && p4_cc_oe_o == 4'h0;
  endproperty
  property p_port_excl; !(|p1_cc_oe_o && |p4_cc_oe_o); endproperty
  property p_p1_quiet; |p4_cc_oe_o |-> p1_cc_o == 4'h0; endproperty
  property p_irq_fall; $fell(irq_o) && !$past(rst_i) |-> $past(ack_o && we_i); endproperty
  property p_oe_write; $changed(p1_cc_oe_o) && !$past(rst_i) |-> $past(ack_o && we_i); endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack");
  a_ack_pulse: assert property (p_ack_pulse) else $error("long ack");
  a_rd_zero: assert property (p_rd_zero) else $error("high read bits");
  a_quiet: assert property (p_quiet) else $error("not quiet after reset");
  a_port_excl: assert property (p_port_excl) else $error("both ports drive");
  a_p1_quiet: assert property (p_p1_quiet) else $error("port 1 active");
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell alone");
  a_oe_write: assert property (p_oe_write) else $error("oe moved alone");
  c_irq: cover property ($rose(irq_o));
  c_pin: cover property ($rose(p1_cc_o[1]));
  c_p4: cover property (|p4_cc_oe_o);
endmodule
bind tcc_top tcc_monitor tcc_monitor_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .dat_o, .ack_o,
  .p1_cc_o, .p1_cc_oe_o, .p4_cc_oe_o, .irq_o);

// ==== tb/tcc_pin_model.sv ====
/* Pin model: a falling-edge train on the event line, levels on the
   trigger and channel pins. Assumes the bench sets its controls. */
`timescale 1ns/1ns
module tcc_pin_model (
  // Controls
  input  wire logic       clk_i,
  input  wire logic       run_i,
  input  wire logic       gate_i,
  input  wire logic       trig_i,
  input  wire logic [3:0] pin_i,
  // Pins
  output logic            event_gate_pin_o,
  output logic            reload_trigger_pin_o,
  output logic [3:0]      p1_cc_o,
  output logic [3:0]      p4_cc_o
);
  logic [2:0] ph = 3'h0;
  // ==========
  // Pin drivers
  // falling edge every six
  always @(posedge clk_i)
  begin
    ph <= (run_i && ph != 3'h5) ? ph + 3'h1 : 3'h0;
    event_gate_pin_o <= run_i ? ph < 3'h3 : gate_i;
    reload_trigger_pin_o <= trig_i;
    p1_cc_o <= pin_i;
    // Port 4 sees the inverse, so a wrong routing shows as a wrong edge.
    p4_cc_o <= ~pin_i;
  end
endmodule

// ==== tb/tcc_top_tb.sv ====
/* Bench of tcc_top: registers, count modes, compare, reload, capture.
   Assumes the pin model and the bound checker. */
`timescale 1ns/1ns
module tcc_top_tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [9:0]  adr_i = 10'h000;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h00000000;
  logic        run = 1'b0;
  logic        gate = 1'b1;
  logic        trig = 1'b1;
  logic [3:0]  pin = 4'h0;
  logic [7:0]  r;
  logic [15:0] a, b, g;
  int          n_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          t;
  logic [7:0]  regs [15] = '{8'h91, 8'hC8, 8'hC9, 8'hC1, 8'hC2, 8'hC3, 8'hC4, 8'hC5,
                             8'hC6, 8'hC7, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'h90};
  logic [7:0]  tm [5] = '{8'h01, 8'h81, 8'h03, 8'h03, 8'h00};
  logic [15:0] tl [5] = '{16'h0013, 16'h0009, 16'h0000, 16'h0013, 16'h0000};
  wire logic [31:0] dat_o;
  wire logic [3:0]  p1_cc_o, p1_cc_oe_o, p4_cc_oe_o, p1i, p4i, p4o;
  wire logic        ack_o, irq_o, evg, trg;
  tcc_top tcc_top_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .event_gate_pin_i(evg), .reload_trigger_pin_i(trg), .p1_cc_i(p1i), .p1_cc_o,
    .p1_cc_oe_o, .p4_cc_i(p4i), .p4_cc_o(p4o), .p4_cc_oe_o, .irq_o);
  tcc_pin_model tcc_pin_model_i (.clk_i, .run_i(run), .gate_i(gate), .trig_i(trig), .pin_i(pin),
    .event_gate_pin_o(evg), .reload_trigger_pin_o(trg), .p1_cc_o(p1i), .p4_cc_o(p4i));
  initial
    forever #4 clk_i = ~clk_i;
  // ==========
  // Tasks
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    comparisons++;
    if ((v >= lo && v <= hi) !== 1'b1)
    begin
      n_errors++;
      $display("Error at %0t: got %h, want %h..%h", $time, v, lo, hi);
    end
  endtask
  // A request stays up until ack is seen, then drops for at least a cycle.
  task automatic bus(input logic w, input logic [7:0] ix, input logic [7:0] v);
    int k;
    k = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, sel_i, adr_i, dat_i} <= {2'b11, w, 4'hF, ix, 2'b00, 24'h000000, v};
    do
      @(posedge clk_i);
    while (ack_o !== 1'b1 && ++k < 50);
    if (ack_o !== 1'b1)
    begin
      n_errors++;
      $display("Error at %0t: no ack", $time);
    end
    r = dat_o[7:0];
    {cyc_i, stb_i, we_i} <= 3'b000;
  endtask
  task automatic wr(input logic [7:0] ix, input logic [7:0] v);
    bus(1'b1, ix, v);
  endtask
  task automatic rd(input logic [7:0] ix, input logic [7:0] e);
    bus(1'b0, ix, 8'h00);
    chk({8'h00, r}, {8'h00, e}, {8'h00, e});
  endtask
  task automatic wv(input logic [7:0] ix, input logic [15:0] v);
    wr(ix, v[7:0]);
    wr(ix + 8'h01, v[15:8]);
  endtask
  task automatic rv(input logic [7:0] ix);
    bus(1'b0, ix, 8'h00);
    g[7:0] = r;
    bus(1'b0, ix + 8'h01, 8'h00);
    g[15:8] = r;
  endtask
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_errors++;
      give_verdict();
    end
  end
  // ==========
  // Tests
  initial
  begin
    void'($urandom(32'h37645818));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (regs[i])
      rd(regs[i], 8'h00);
    for (int i = 4; i < 12; i++)
    begin
      b[7:0] = 8'($urandom);
      wr(regs[i], b[7:0]);
      rd(regs[i], b[7:0]);
    end
    $display("register test done");
    for (int i = 0; i < 5; i++)
    begin
      wr(8'hC8, 8'h00);
      wv(8'hCC, 16'h0000);
      gate <= i != 2;
      wr(8'hC8, tm[i]);
      repeat (240) @(posedge clk_i);
      wr(8'hC8, 8'h00);
      rv(8'hCC);
      chk(g, tl[i], tl[i] == 16'h0000 ? 16'h0000 : tl[i] + 16'h0002);
    end
    wr(8'hC8, 8'h02);
    run <= 1'b1;
    repeat (60) @(posedge clk_i);
    run <= 1'b0;
    repeat (4) @(posedge clk_i);
    wr(8'hC8, 8'h00);
    rv(8'hCC);
    chk(g, 16'h000A, 16'h000A);
    $display("count test done");
    wr(8'hC9, 8'h20);
    wr(8'hC1, 8'h08);
    wv(8'hC2, 16'h0010);
    wv(8'hCC, 16'h0000);
    chk({12'h000, p1_cc_oe_o}, 16'h0002, 16'h0002);
    wr(8'hC8, 8'h01);
    for (t = 0; t < 400 && p1_cc_o[1] !== 1'b1; t++)
      @(posedge clk_i);
    wr(8'hC8, 8'h00);
    rv(8'hCC);
    chk(g, 16'h0010, 16'h0011);
    rd(8'hC9, 8'h22);
    wr(8'hC9, 8'h02);
    @(negedge clk_i);
    chk({15'h0000, irq_o}, 16'h0000, 16'h0000);
    wr(8'hC9, 8'h22);
    @(negedge clk_i);
    chk({15'h0000, irq_o}, 16'h0001, 16'h0001);
    wr(8'hC9, 8'h20);
    rd(8'hC9, 8'h20);
    wv(8'hCC, 16'hFFF0);
    wr(8'hC8, 8'h01);
    for (t = 0; t < 400 && p1_cc_o[1] !== 1'b0; t++)
      @(posedge clk_i);
    wr(8'hC8, 8'h00);
    rv(8'hCC);
    chk(g, 16'h0000, 16'h0001);
    wr(8'hC8, 8'h04);
    wr(8'hCE, 8'h02);
    wv(8'hCC, 16'h0000);
    wr(8'hC8, 8'h05);
    for (t = 0; t < 400 && p1_cc_o[1] !== 1'b1; t++)
      @(posedge clk_i);
    wr(8'hC8, 8'h04);
    wv(8'hCC, 16'hFFF0);
    wr(8'hC8, 8'h05);
    repeat (250) @(posedge clk_i);
    chk({15'h0000, p1_cc_o[1]}, 16'h0001, 16'h0001);
    wr(8'hC8, 8'h00);
    wr(8'hCE, 8'h00);
    rd(8'hCE, 8'h22);
    $display("compare test done");
    wr(8'hC1, 8'h00);
    b = 16'($urandom) & 16'h7FFF;
    wv(8'hCA, b);
    wv(8'hCC, 16'hFFF0);
    wr(8'hC8, 8'h11);
    repeat (250) @(posedge clk_i);
    wr(8'hC8, 8'h00);
    rv(8'hCC);
    chk(g, b + 16'h0004, b + 16'h0006);
    wv(8'hCC, 16'h0000);
    wr(8'hC8, 8'h18);
    trig <= 1'b0;
    repeat (4) @(posedge clk_i);
    trig <= 1'b1;
    rv(8'hCC);
    chk(g, b, b);
    $display("reload test done");
    for (int i = 0; i < 3; i++)
    begin
      wr(8'h91, i == 2 ? 8'h40 : 8'h00);
      wr(8'hC8, i == 1 ? 8'h40 : 8'h00);
      wr(8'hC1, i == 2 ? 8'h40 : 8'h01);
      a = 16'($urandom);
      b = ~a;
      wv(8'hCC, a);
      pin[i == 2 ? 3 : 0] <= 1'b1;
      repeat (3) @(posedge clk_i);
      wv(8'hCC, b);
      pin[i == 2 ? 3 : 0] <= 1'b0;
      repeat (3) @(posedge clk_i);
      rv(i == 2 ? 8'hC6 : 8'hCA);
      chk(g, i == 1 ? a : b, i == 1 ? a : b);
    end
    wr(8'hC1, 8'h80);
    @(negedge clk_i);
    chk({8'h00, p4_cc_oe_o, p1_cc_oe_o}, 16'h0080, 16'h0080);
    chk({8'h00, p4o, p1_cc_o}, 16'h0020, 16'h0020);
    wr(8'hC1, 8'h33);
    wv(8'hCC, a);
    for (int i = 0; i < 2; i++)
    begin
      wr(8'hCA - 8'(6 * i), 8'h5A);
      rv(8'hCA - 8'(6 * i));
      chk(g, a, a);
    end
    $display("capture test done");
    give_verdict();
  end
endmodule
